// ===== inc/sensor_i2c_pkg.sv
package sensor_i2c_pkg;
  // target addresses selected by the strap pin
  localparam logic [6:0] TARGET_ADDR_LOW = 7'h18;
  localparam logic [6:0] TARGET_ADDR_HIGH = 7'h19;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CTRL_ACK_SEEN = 4'h9;
  localparam int CLK_KHZ = 200000;
  localparam int WDT_SHORT_US = 1000;
  localparam int WDT_LONG_US = 50000;
  localparam int WDT_SHORT_CYC = WDT_SHORT_US * (CLK_KHZ / 1000);
  localparam int WDT_LONG_CYC = WDT_LONG_US * (CLK_KHZ / 1000);
  localparam int WDT_W = 24;
  // idle the controller keeps after a write, by power mode
  localparam int IDLE_NORMAL_US = 2;
  localparam int IDLE_SUSPEND_US = 450;
  localparam int WBUF_DEPTH = 2;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;
  localparam int WBUF_W = $bits(reg_write_t);
  typedef enum logic [3:0] {
    st_idle, st_addr, st_aack, st_reg, st_rack, st_wdat, st_push,
    st_wack, st_rdat, st_mack, st_ign
  } state_t;
endpackage

// ===== hdl/sensor_i2c_target_port.sv
`timescale 1ns/1ps
// Operation
// RQ1: target in standard and fast mode, 7-bit addressing only.
// RQ2: answer 0x18 with strap low, 0x19 with strap high.
// RQ3: data falling while clock high is start; bus busy afterwards.
// RQ4: data rising while clock high is stop; detected, transfer ends.
// RQ5: receiver holds data low through the ninth clock high phase.
// RQ6: stop right after start without clock low is ignored.
// RQ7: write: address with write bit, register address, one data byte.
// RQ8: acknowledge register address and data byte; one byte per write.
// RQ9: read uses write phase, repeated start, address with read bit.
// RQ10: send bytes while acknowledged; release line on not-acknowledge.
// RQ11: register pointer increments after each byte read; the code steps it only when the controller acknowledges the byte.
// RQ12: each read starts at the last written register address.
// RQ13: read start pointer is zero until an address is written.
// RQ14: watchdog resets the interface when the device locks the bus.
// RQ15: watchdog enable bit turns the watchdog on or off.
// RQ16: period select chooses 1 ms when 0, 50 ms when 1.
// RQ17: controller idles 2 us or 450 us after every write.
// RQ18: foreign address leaves data released, rest of transfer ignored.
module sensor_i2c_target_port #(
  parameter int WDT_SHORT_CYCLES = sensor_i2c_pkg::WDT_SHORT_CYC,
  parameter int WDT_LONG_CYCLES = sensor_i2c_pkg::WDT_LONG_CYC,
  parameter int FIFO_DEPTH = sensor_i2c_pkg::WBUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic shared_clock_pin_i,
  output logic shared_clock_pin_o,
  output logic shared_clock_pin_oe,
  input wire logic shared_data_pin_i,
  output logic shared_data_pin_o,
  output logic shared_data_pin_oe,
  input wire logic address_select_pin,
  input wire logic watchdog_enable,
  input wire logic watchdog_long_sel,
  output logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  output logic wr_valid,
  input wire logic wr_ready,
  output sensor_i2c_pkg::reg_write_t wr_word,
  output logic bus_busy
);
  import sensor_i2c_pkg::*;

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, strap_m, strap_s;
  state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt;
  logic [7:0] ptr_r, ptr_nxt, start_ptr_r, start_ptr_nxt;
  logic oe_r, oe_nxt, rw_r, rw_nxt, seen_low_r, seen_low_nxt;
  logic [WDT_W-1:0] wdt_cnt_r, wdt_cnt_nxt;
  logic [WBUF_W-1:0] mem_r [FIFO_DEPTH];
  logic [PW-1:0] wp_r, rp_r;
  logic [PW:0] fill_r;

  // inputs from the pins pass two flops before anything looks at them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {strap_m, strap_s} <= 2'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {shared_clock_pin_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {shared_data_pin_i, sda_m, sda_s};
      {strap_m, strap_s} <= {address_select_pin, strap_m};
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s; // [RQ3]
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s; // [RQ4]
  wire stop_ok = stop_det & seen_low_r; // [RQ6]
  wire [6:0] my_addr = strap_s ? TARGET_ADDR_HIGH : TARGET_ADDR_LOW; // [RQ2]
  // only seven address bits exist; a 10-bit header never matches [RQ1]
  wire addr_hit = (sh_r[7:1] == my_addr);
  wire byte_end = scl_fall & (cnt_r == BITS_PER_BYTE);
  wire in_ready = (fill_r != (PW + 1)'(FIFO_DEPTH));
  wire [WDT_W-1:0] wdt_lim = watchdog_long_sel ?
    WDT_W'(WDT_LONG_CYCLES) : WDT_W'(WDT_SHORT_CYCLES); // [RQ16]
  // counts only while this end holds a line low and the clock stands
  wire wdt_active = watchdog_enable & (oe_r | shared_clock_pin_oe); // [RQ15]
  wire wdt_fire = wdt_active & (wdt_cnt_r >= wdt_lim - 1'b1); // [RQ14]
  // a watchdog reset drops the stalled word rather than half-ending it
  wire push = (state_r == st_push) & in_ready & ~wdt_fire;
  wire pop = wr_valid & wr_ready;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    start_ptr_nxt = start_ptr_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    seen_low_nxt = start_det ? 1'b0 : (scl_fall ? 1'b1 : seen_low_r);
    wdt_cnt_nxt = (!wdt_active || scl_rise || scl_fall) ? '0 :
      wdt_cnt_r + 1'b1;
    if (wdt_fire) begin
      state_nxt = st_idle; // [RQ14]
      oe_nxt = 1'b0;
    end else if (stop_ok) begin
      state_nxt = st_idle; // [RQ4]
      oe_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = st_addr; // [RQ3] [RQ9]
      cnt_nxt = '0;
      oe_nxt = 1'b0;
    end else begin
      case (state_r)
        st_addr, st_reg, st_wdat: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 1'b1;
          end
          if (byte_end) begin
            if (state_r == st_wdat) begin
              // clock is stretched until the buffer takes the word
              state_nxt = st_push;
            end else if (state_r == st_reg) begin
              state_nxt = st_rack; // [RQ8]
              oe_nxt = 1'b1;
              ptr_nxt = sh_r;
              start_ptr_nxt = sh_r; // [RQ12]
            end else if (addr_hit) begin
              state_nxt = st_aack; // [RQ5]
              oe_nxt = 1'b1;
              rw_nxt = sh_r[0];
              ptr_nxt = sh_r[0] ? start_ptr_r : ptr_r; // [RQ12] [RQ13]
            end else begin
              state_nxt = st_ign; // [RQ18]
            end
          end
        end
        st_aack: begin
          if (scl_fall) begin
            cnt_nxt = '0;
            if (rw_r) begin
              state_nxt = st_rdat; // [RQ10]
              tx_nxt = reg_rdata;
              oe_nxt = ~reg_rdata[7];
            end else begin
              state_nxt = st_reg; // [RQ7]
              oe_nxt = 1'b0;
            end
          end
        end
        st_rack: begin
          if (scl_fall) begin
            state_nxt = st_wdat; // [RQ7]
            cnt_nxt = '0;
            oe_nxt = 1'b0;
          end
        end
        st_push: begin
          if (push) begin
            state_nxt = st_wack; // [RQ8]
            oe_nxt = 1'b1;
          end
        end
        st_wack: begin
          // further data bytes are not taken: one byte per sequence
          if (scl_fall) begin
            state_nxt = st_ign; // [RQ8]
            oe_nxt = 1'b0;
          end
        end
        st_rdat: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 1'b1;
          end
          if (byte_end) begin
            state_nxt = st_mack; // [RQ5]
            oe_nxt = 1'b0;
          end else if (scl_fall) begin
            tx_nxt = {tx_r[6:0], 1'b0};
            oe_nxt = ~tx_r[6];
          end
        end
        st_mack: begin
          if (scl_rise) begin
            if (!sda_s) begin
              cnt_nxt = CTRL_ACK_SEEN;
              ptr_nxt = ptr_r + PTR_STEP; // [RQ11]
            end else begin
              state_nxt = st_ign; // [RQ10]
            end
          end else if (scl_fall && cnt_r == CTRL_ACK_SEEN) begin
            state_nxt = st_rdat; // [RQ10]
            cnt_nxt = '0;
            tx_nxt = reg_rdata;
            oe_nxt = ~reg_rdata[7];
          end
        end
        st_ign: oe_nxt = 1'b0; // [RQ18]
        st_idle: oe_nxt = 1'b0;
        default: begin
          state_nxt = st_idle;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= st_idle;
      cnt_r <= '0;
      sh_r <= '0;
      tx_r <= '0;
      ptr_r <= PTR_RESET;
      start_ptr_r <= PTR_RESET; // [RQ13]
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      seen_low_r <= 1'b0;
      wdt_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      start_ptr_r <= start_ptr_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      seen_low_r <= seen_low_nxt;
      wdt_cnt_r <= wdt_cnt_nxt;
    end
  end

  // two-entry write buffer between the bus and the register file
  genvar g;
  generate
    for (g = 0; g < FIFO_DEPTH; g++) begin : g_wbuf
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_r[g] <= '0;
        end else if (push && wp_r == PW'(g)) begin
          mem_r[g] <= {ptr_r, sh_r}; // [RQ7]
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      fill_r <= '0;
    end else begin
      wp_r <= push ? ptr_inc(wp_r) : wp_r;
      rp_r <= pop ? ptr_inc(rp_r) : rp_r;
      fill_r <= fill_r + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  assign wr_valid = (fill_r != '0);
  assign wr_word = mem_r[rp_r];
  assign reg_addr = ptr_r;
  assign bus_busy = (state_r != st_idle); // [RQ3]
  assign shared_data_pin_o = 1'b0;
  assign shared_data_pin_oe = oe_r; // [RQ5]
  assign shared_clock_pin_o = 1'b0;
  assign shared_clock_pin_oe = (state_r == st_push);

  property p_foreign;
    @(posedge clk) disable iff (rst)
    (state_r == st_addr && byte_end && !addr_hit && !wdt_fire &&
     !stop_ok && !start_det) |=> (state_r == st_ign) && !oe_r;
  endproperty
  a_foreign: assert property (p_foreign) // [RQ18]
    else $error("foreign address not ignored");
  property p_ack_low;
    @(posedge clk) disable iff (rst)
    (state_r == st_aack || state_r == st_rack || state_r == st_wack)
      |-> oe_r;
  endproperty
  a_ack_low: assert property (p_ack_low) // [RQ5]
    else $error("ack bit not driven low");
  property p_start;
    @(posedge clk) disable iff (rst)
    (start_det && !wdt_fire && !stop_ok) |=> state_r == st_addr && bus_busy;
  endproperty
  a_start: assert property (p_start) // [RQ3]
    else $error("start not taken");
  property p_stop;
    @(posedge clk) disable iff (rst)
    stop_ok |=> (state_r == st_idle) && !oe_r && !bus_busy;
  endproperty
  a_stop: assert property (p_stop) // [RQ4]
    else $error("stop not taken");
  property p_bare_stop;
    @(posedge clk) disable iff (rst)
    (stop_det && !seen_low_r && state_r == st_addr && !wdt_fire)
      |=> state_r == st_addr;
  endproperty
  a_bare_stop: assert property (p_bare_stop) // [RQ6]
    else $error("stop directly after start honoured");
  property p_nack;
    @(posedge clk) disable iff (rst)
    (state_r == st_mack && scl_rise && sda_s && !stop_ok && !wdt_fire &&
     !start_det) |=> (state_r == st_ign) ##1 !oe_r;
  endproperty
  a_nack: assert property (p_nack) // [RQ10]
    else $error("not-acknowledge did not end the read");
  property p_inc;
    @(posedge clk) disable iff (rst)
    (state_r == st_mack && scl_rise && !sda_s && !wdt_fire && !stop_ok &&
     !start_det) |=> ptr_r == $past(ptr_r) + PTR_STEP;
  endproperty
  a_inc: assert property (p_inc) // [RQ11]
    else $error("pointer not advanced after read byte");
  property p_read_start;
    @(posedge clk) disable iff (rst)
    (state_r == st_addr && byte_end && addr_hit && sh_r[0] && !wdt_fire &&
     !stop_ok && !start_det) |=> ptr_r == $past(start_ptr_r);
  endproperty
  a_read_start: assert property (p_read_start) // [RQ12]
    else $error("read did not start at last written address");
  property p_wdt;
    @(posedge clk) disable iff (rst)
    wdt_fire |=> (state_r == st_idle) && !oe_r && !shared_clock_pin_oe;
  endproperty
  a_wdt: assert property (p_wdt) // [RQ14]
    else $error("watchdog did not release the bus");
  property p_wdt_off;
    @(posedge clk) disable iff (rst)
    !watchdog_enable |=> wdt_cnt_r == '0;
  endproperty
  a_wdt_off: assert property (p_wdt_off) // [RQ15]
    else $error("watchdog counts while disabled");
  property p_one_byte;
    @(posedge clk) disable iff (rst)
    push |=> (state_r == st_wack) && oe_r && fill_r != '0;
  endproperty
  a_one_byte: assert property (p_one_byte) // [RQ8]
    else $error("data byte not buffered and acknowledged");
  c_write: cover property (@(posedge clk) disable iff (rst) push);
  c_read_more: cover property (@(posedge clk) disable iff (rst)
    state_r == st_mack && cnt_r == CTRL_ACK_SEEN);
  c_nack: cover property (@(posedge clk) disable iff (rst)
    state_r == st_mack ##1 state_r == st_ign);
  c_stall: cover property (@(posedge clk) disable iff (rst)
    state_r == st_push && !in_ready);
endmodule // sensor_i2c_target_port

// ===== verif/i2c_ctrl_model.sv
`timescale 1ns/1ps
module i2c_ctrl_model #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic hp();
    repeat (HALF) @(posedge clk);
    #1;
  endtask
  // release the clock, bounded wait while the target stretches it
  task automatic rise();
    scl_low = 1'b0;
    for (int i = 0; i < 4000 && scl_in !== 1'b1; i++) @(posedge clk);
    #1;
    hp();
  endtask
  // data falls while clock is high; also the repeated start
  task automatic start();
    sda_low = 1'b0;
    hp();
    rise();
    sda_low = 1'b1;
    hp();
    scl_low = 1'b1;
    hp();
  endtask
  // entered with clock low, so a low phase always precedes it
  task automatic stop();
    sda_low = 1'b1;
    hp();
    rise();
    sda_low = 1'b0;
    hp();
  endtask
  // a one releases the data line so the target may drive it
  task automatic bit_x(input logic b, output logic r);
    sda_low = ~b;
    hp();
    rise();
    r = sda_in;
    scl_low = 1'b1;
  endtask
  // msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack,
                      output logic [7:0] q, output logic seen);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack, seen);
  endtask
endmodule // i2c_ctrl_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sensor_i2c_pkg::*;
  localparam int SHORT = 50;
  localparam int LONG = 200;
  logic clk, rst, strap, wdt_en, wdt_long, wr_ready, ack, r;
  logic scl_oe, sda_oe, busy, wr_valid, m_scl, m_sda, scl, sda;
  logic scl_o, sda_o;
  logic [7:0] reg_addr, reg_rdata, q;
  reg_write_t wr_word;
  int err_count, n_compared;
  // pull-ups: a line is low only where an enabled driver pulls it low
  assign scl = ~m_scl & (~scl_oe | scl_o);
  assign sda = ~m_sda & (~sda_oe | sda_o);
  // bit 7 low on small addresses, so a byte sent past a nack shows
  assign reg_rdata = reg_addr ^ 8'h5a;
  sensor_i2c_target_port #(.WDT_SHORT_CYCLES(SHORT),
    .WDT_LONG_CYCLES(LONG), .FIFO_DEPTH(WBUF_DEPTH)) uut (
    .clk(clk), .rst(rst), .shared_clock_pin_i(scl),
    .shared_clock_pin_o(scl_o), .shared_clock_pin_oe(scl_oe),
    .shared_data_pin_i(sda), .shared_data_pin_o(sda_o),
    .shared_data_pin_oe(sda_oe), .address_select_pin(strap),
    .watchdog_enable(wdt_en), .watchdog_long_sel(wdt_long),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_word(wr_word), .bus_busy(busy));
  i2c_ctrl_model ctl (.clk(clk), .scl_in(scl), .sda_in(sda),
    .scl_low(m_scl), .sda_low(m_sda));
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic addr(input logic [6:0] dev, input logic rd, input logic e);
    ctl.start();
    check("busy", busy, 1'b1);
    ctl.xfer({dev, rd}, 1'b1, q, ack);
    check("addr ack", ack, e);
  endtask
  // idle after stop long enough for the normal power mode slot (2 us), not the suspend slot
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra,
                    input logic [7:0] d, input logic extra);
    addr(dev, 1'b0, 1'b0);
    ctl.xfer(ra, 1'b1, q, ack);
    check("reg ack", ack, 1'b0);
    ctl.xfer(d, 1'b1, q, ack);
    check("data ack", ack, 1'b0);
    if (extra) ctl.xfer(8'h22, 1'b1, q, ack);
    if (extra) check("extra nack", ack, 1'b1);
    ctl.stop();
    cyc(IDLE_NORMAL_US * 200);
    check("idle", busy, 1'b0);
  endtask
  task automatic pop(input logic [7:0] ra, input logic [7:0] d);
    for (int i = 0; i < 3000 && wr_valid !== 1'b1; i++) @(posedge clk);
    #1;
    check("wr_valid", wr_valid, 1'b1);
    check("wr_word", wr_word, {ra, d});
    wr_ready = 1'b1;
    cyc(1);
    wr_ready = 1'b0;
  endtask
  task automatic rd(input int n, input logic [7:0] a);
    addr(TARGET_ADDR_LOW, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      ctl.xfer(8'hff, i == n - 1, q, ack);
      check("rdata", q, (a + 8'(i)) ^ 8'h5a);
    end
    ctl.hp();
    check("released", sda_oe, 1'b0);
    ctl.stop();
    cyc(20);
  endtask
  // address with write bit, then the clock is kept low through the ack
  task automatic stall();
    logic [7:0] a;
    a = {TARGET_ADDR_LOW, 1'b0};
    ctl.start();
    for (int i = 7; i >= 0; i--) ctl.bit_x(a[i], r);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    cyc(60000);
    err_count++;
    conclude();
  end
  initial begin
    {rst, strap, wdt_en, wdt_long, wr_ready} = 5'b10000;
    err_count = 0;
    n_compared = 0;
    cyc(10);
    rst = 1'b0;
    cyc(5);
    rd(2, PTR_RESET);
    $display("test reset pointer done");
    wr(TARGET_ADDR_LOW, 8'h10, 8'h09, 1'b0);
    pop(8'h10, 8'h09);
    wr(TARGET_ADDR_LOW, 8'h30, 8'h11, 1'b1);
    pop(8'h30, 8'h11);
    cyc(4);
    check("one word", wr_valid, 1'b0);
    $display("test write done");
    addr(TARGET_ADDR_LOW, 1'b0, 1'b0);
    ctl.xfer(8'h02, 1'b1, q, ack);
    rd(3, 8'h02);
    rd(2, 8'h02);
    $display("test read done");
    addr(TARGET_ADDR_HIGH, 1'b0, 1'b1);
    ctl.stop();
    addr(7'h78, 1'b0, 1'b1);
    ctl.stop();
    cyc(20);
    strap = 1'b1;
    cyc(10);
    wr(TARGET_ADDR_HIGH, 8'h20, 8'h5c, 1'b0);
    pop(8'h20, 8'h5c);
    strap = 1'b0;
    $display("test address done");
    wr(TARGET_ADDR_LOW, 8'h01, 8'h0a, 1'b0);
    wr(TARGET_ADDR_LOW, 8'h02, 8'h0b, 1'b0);
    fork
      wr(TARGET_ADDR_LOW, 8'h03, 8'h0c, 1'b0);
      begin
        cyc(700);
        check("stretch", scl_oe, 1'b1);
        pop(8'h01, 8'h0a);
        pop(8'h02, 8'h0b);
        pop(8'h03, 8'h0c);
      end
    join
    $display("test buffer done");
    ctl.sda_low = 1'b1;
    ctl.hp();
    ctl.sda_low = 1'b0;
    cyc(20);
    check("stop ignored", busy, 1'b1);
    wr(TARGET_ADDR_LOW, 8'h04, 8'h0d, 1'b0);
    pop(8'h04, 8'h0d);
    $display("test start stop done");
    stall();
    cyc(LONG + 20);
    check("wdt off", sda_oe, 1'b1);
    {wdt_en, wdt_long} = 2'b11;
    cyc(SHORT + 20);
    check("wdt long", sda_oe, 1'b1);
    cyc(LONG);
    check("wdt long", sda_oe, 1'b0);
    ctl.stop();
    wdt_long = 1'b0;
    stall();
    cyc(SHORT + 10);
    check("wdt short", sda_oe, 1'b0);
    check("wdt idle", busy, 1'b0);
    ctl.stop();
    $display("test watchdog done");
    conclude();
  end
endmodule // tb_top
